// [rtl/optical_mgmt_port.sv]
// Management logic of a pluggable optical module: pins, monitors, flags
// and the two-wire serial slave that reads them.
// Assumes monitor bytes arrive from an ADC on clk_i; serial clock from host.
// Function
// R1 - Serial commands answered only while select input is low.
// R2 - Interrupt output low while an important condition exists.
// R3 - Transmit disable input switches the laser off.
// R4 - Laser off and back on well within 100 ms.
// R5 - Presence output held low by the module.
// R6 - Receive loss output high without signal, low while receiving.
// R7 - Power-down high keeps the module in standby.
// R8 - Power-down falling edge fully resets module and serial logic.
// R9 - Host drives serial clock; module never drives it.
// R10 - Data sampled on rising clock; protected bytes are not written.
// R11 - Returned data changes on the falling serial clock edge.
// R12 - Host frames transfers with start and stop conditions.
// R13 - Memory is bytes, reached singly or in sequential runs.
// R14 - Random and sequential access from address zero upward.
// R15 - Temperature, bias, tx power, rx power, supply readable live.
// R16 - Alarm and warning flags set outside factory ranges.
// R17 - No reference clock needed for any function.
// R18 - Diagnostics reached only over the serial interface.
// R19 - Not-ready held after reset until monitor data is valid.
// R20 - Interrupt asserted while any alarm or warning is pending.
`timescale 1ns/1ps
module optical_mgmt_port
	import optical_mgmt_pkg::*;
#(
	parameter int INIT_CYCLES = optical_mgmt_pkg::INIT_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	input  wire logic       mod_desel_i,
	input  wire logic       laser_off_request_i,
	input  wire logic       power_down_i,
	input  wire logic       rx_signal_detect_i,
	input  wire logic [7:0] mon_temp_i,
	input  wire logic [7:0] mon_bias_i,
	input  wire logic [7:0] mon_txpwr_i,
	input  wire logic [7:0] mon_rxpwr_i,
	input  wire logic [7:0] mon_vcc_i,
	output logic            interrupt_n_o,
	output logic            mod_absent_o,
	output logic            not_ready_flag_o,
	output logic            receive_signal_lost_o,
	output logic            laser_enable_o,
	output logic            standby_o
);
	import optical_mgmt_pkg::*;

	// ==========================================================
	// Core clock state
	typedef struct packed {
		logic                  scl_s1;
		logic                  scl_s2;
		logic                  scl_d;
		logic                  sda_s1;
		logic                  sda_s2;
		logic                  sda_d;
		logic                  desel_s1;
		logic                  desel_s2;
		logic                  txdis_s1;
		logic                  txdis_s2;
		logic                  pd_s1;
		logic                  pd_s2;
		logic                  pd_d;
		logic                  sig_s1;
		logic                  sig_s2;
		logic                  frame;
		logic                  link_run;
		logic [1:0]            clr_cnt;
		logic                  full_run;
		logic [INIT_CW-1:0]    init_cnt;
		logic                  ready;
		logic [8:0][7:0]       snap;
		logic [FLAG_W-1:0]     flags;
		logic                  irq_n;
		logic                  absent;
		logic                  not_ready;
		logic                  los;
		logic                  laser_en;
		logic                  standby;
		logic                  sda_out;
	} core_t;

	// Serial engine state, cleared by every start or stop
	typedef struct packed {
		phase_t                phase;
		logic [3:0]            bitcnt;
		logic [7:0]            shreg;
		logic                  ack;
		logic [7:0]            txbyte;
	} link_t;

	localparam logic [INIT_CW-1:0] INIT_LAST = INIT_CW'(INIT_CYCLES - 1);

	core_t              s;
	core_t              next_s;
	link_t              l;
	link_t              next_l;
	logic [7:0]         ptr;
	logic [7:0]         next_ptr;
	logic               drive_rel;
	logic               next_drive_rel;
	logic               mem_we;
	logic [MEM_DW-1:0]  mem_rdata;
	logic               link_arst_n;
	logic               full_arst_n;
	logic               start_seen;
	logic               stop_seen;
	logic               pd_fall;
	logic               blocked;
	logic [7:0]         byte_in;

	// Four range flags of one monitored byte: alarm hi, alarm lo, warn hi, warn lo
	function automatic logic [3:0] range_flags(input logic [7:0] v, input int idx);
		range_flags = {v > ALARM_HI[idx], v < ALARM_LO[idx],
			v > WARN_HI[idx], v < WARN_LO[idx]}; // R16
	endfunction : range_flags

	// Byte returned for a serial read address
	function automatic logic [7:0] read_byte(input logic [7:0] a, input logic [8:0][7:0] snap,
		input logic [7:0] user);
		if (a >= USER_BASE) begin
			read_byte = user;
		end else if (a <= ADDR_STATUS) begin
			read_byte = snap[a[3:0]]; // R15
		end else begin
			read_byte = 8'h00;
		end
	endfunction : read_byte

	// ==========================================================
	// Core logic: pin synchronisers, framing watch, init, monitors
	always_comb begin
		next_s = s;
		next_s.scl_s1 = scl_i;
		next_s.scl_s2 = s.scl_s1;
		next_s.scl_d = s.scl_s2;
		next_s.sda_s1 = sda_i;
		next_s.sda_s2 = s.sda_s1;
		next_s.sda_d = s.sda_s2;
		next_s.desel_s1 = mod_desel_i;
		next_s.desel_s2 = s.desel_s1;
		next_s.txdis_s1 = laser_off_request_i;
		next_s.txdis_s2 = s.txdis_s1;
		next_s.pd_s1 = power_down_i;
		next_s.pd_s2 = s.pd_s1;
		next_s.pd_d = s.pd_s2;
		next_s.sig_s1 = rx_signal_detect_i;
		next_s.sig_s2 = s.sig_s1;

		// Data line moving while clock high marks a frame edge
		start_seen = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2; // R12
		stop_seen = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2; // R12
		pd_fall = s.pd_d & ~s.pd_s2;
		blocked = s.desel_s2 | s.pd_s2 | ~s.ready;

		if (start_seen) begin
			next_s.frame = 1'b1;
		end else if (stop_seen) begin
			next_s.frame = 1'b0;
		end

		// Init counter; a power-down release restarts everything like power-up
		if (pd_fall) begin
			next_s.full_run = 1'b0; // R8
			next_s.init_cnt = '0; // R8
			next_s.ready = 1'b0; // R8
			next_s.flags = '0; // R8
			next_s.frame = 1'b0; // R8
		end else begin
			next_s.full_run = 1'b1;
			if (!s.ready && !s.pd_s2) begin
				if (s.init_cnt == INIT_LAST) begin
					next_s.ready = 1'b1; // R19
				end else begin
					next_s.init_cnt = s.init_cnt + 1'b1;
				end
			end
		end

		// Engine reset pulse on each frame edge; held while deselected
		if (start_seen || stop_seen || blocked || pd_fall) begin
			next_s.link_run = 1'b0; // R1
			next_s.clr_cnt = LINK_CLR_CYC;
		end else if (s.clr_cnt != 2'h0) begin
			next_s.clr_cnt = s.clr_cnt - 1'b1;
		end else begin
			next_s.link_run = 1'b1;
		end

		// Snapshot is frozen during a frame so the serial side reads stable bytes
		if (s.ready && !s.frame && !pd_fall) begin
			next_s.snap[0] = mon_temp_i; // R15
			next_s.snap[1] = mon_bias_i; // R15
			next_s.snap[2] = mon_txpwr_i; // R15
			next_s.snap[3] = mon_rxpwr_i; // R15
			next_s.snap[4] = mon_vcc_i; // R15
			next_s.snap[ADDR_FLAG0[3:0]] = s.flags[7:0]; // R16
			next_s.snap[ADDR_FLAG0[3:0]+4'h1] = s.flags[15:8]; // R16
			next_s.snap[ADDR_FLAG0[3:0]+4'h2] = {4'h0, s.flags[19:16]}; // R16
			next_s.snap[ADDR_STATUS[3:0]] = {4'h0, s.txdis_s2, s.pd_s2, ~s.sig_s2, ~s.ready};
		end
		if (s.ready && !pd_fall) begin
			next_s.flags = {range_flags(mon_vcc_i, 4), range_flags(mon_rxpwr_i, 3),
				range_flags(mon_txpwr_i, 2), range_flags(mon_bias_i, 1),
				range_flags(mon_temp_i, 0)}; // R16
		end

		// Pin outputs
		next_s.irq_n = ~(s.ready & (|s.flags)); // R2 R20
		next_s.absent = 1'b0; // R5
		next_s.not_ready = ~s.ready; // R19
		next_s.los = ~s.sig_s2; // R6
		next_s.laser_en = s.ready & ~s.txdis_s2 & ~s.pd_s2; // R3 R4
		next_s.standby = s.pd_s2; // R7
		next_s.sda_out = 1'b0;
	end

	// Core registers; no reference clock is used anywhere
	always_ff @(posedge clk_i or negedge rst_n_i) begin // R17
		if (!rst_n_i) begin
			s <= '0;
			s.snap <= {9{SNAP_RST}};
			s.irq_n <= 1'b1;
			s.not_ready <= 1'b1;
			s.los <= 1'b1;
			s.scl_s1 <= 1'b1;
			s.scl_s2 <= 1'b1;
			s.scl_d <= 1'b1;
			s.sda_s1 <= 1'b1;
			s.sda_s2 <= 1'b1;
			s.sda_d <= 1'b1;
			s.desel_s1 <= 1'b1;
			s.desel_s2 <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign interrupt_n_o = s.irq_n;
	assign mod_absent_o = s.absent;
	assign not_ready_flag_o = s.not_ready;
	assign receive_signal_lost_o = s.los;
	assign laser_enable_o = s.laser_en;
	assign standby_o = s.standby;
	assign sda_o = s.sda_out;

	// ==========================================================
	// Serial clock domain resets: both come from core flip-flops
	assign link_arst_n = rst_n_i & s.link_run;
	assign full_arst_n = rst_n_i & s.full_run;

	// ==========================================================
	// Serial engine, sampled on the rising serial clock
	always_comb begin
		next_l = l;
		next_ptr = ptr;
		mem_we = 1'b0;
		byte_in = {l.shreg[6:0], sda_i};
		if (l.bitcnt == 4'h8) begin
			next_l.bitcnt = 4'h0;
			next_l.ack = 1'b0;
			if (l.phase == PH_READ) begin
				if (!l.ack && sda_i) begin
					next_l.phase = PH_IGNORE;
				end else begin
					next_l.txbyte = read_byte(ptr, s.snap, mem_rdata); // R13 R18
				end
			end
		end else begin
			next_l.shreg = byte_in; // R10
			next_l.bitcnt = l.bitcnt + 1'b1;
			if (l.phase == PH_READ && l.bitcnt == 4'h0) begin
				next_ptr = ptr + 1'b1; // R14
			end
			if (l.bitcnt == 4'h7) begin
				unique case (l.phase)
					PH_DEV: begin
						if (byte_in[7:1] == DEV_ADDR) begin
							next_l.ack = 1'b1;
							next_l.phase = byte_in[0] ? PH_READ : PH_WORD;
						end else begin
							next_l.phase = PH_IGNORE;
						end
					end
					PH_WORD: begin
						next_ptr = byte_in; // R14
						next_l.ack = 1'b1;
						next_l.phase = PH_WRITE;
					end
					PH_WRITE: begin
						mem_we = (ptr >= USER_BASE); // R10
						next_ptr = ptr + 1'b1; // R13
						next_l.ack = 1'b1;
					end
					PH_READ, PH_IGNORE: begin
						next_l.ack = 1'b0;
					end
				endcase
			end
		end

		// Taken from the settled engine state, not the next one, so the ack slot
		// and each read bit start at the falling edge that follows their rising edge
		if (l.bitcnt == 4'h8) begin
			next_drive_rel = ~l.ack;
		end else if (l.phase == PH_READ) begin
			next_drive_rel = l.txbyte[~l.bitcnt[2:0]];
		end else begin
			next_drive_rel = 1'b1;
		end
	end

	// Engine state; any frame edge restarts it at the device byte
	always_ff @(posedge scl_i or negedge link_arst_n) begin // R9
		if (!link_arst_n) begin
			l <= '0;
			l.phase <= PH_DEV;
		end else begin
			l <= next_l;
		end
	end

	// Address survives a repeated start so a random read can follow
	always_ff @(posedge scl_i or negedge full_arst_n) begin
		if (!full_arst_n) begin
			ptr <= 8'h00; // R8 R14
		end else begin
			ptr <= next_ptr;
		end
	end

	// Data line changes only on the falling serial clock
	always_ff @(negedge scl_i or negedge link_arst_n) begin
		if (!link_arst_n) begin
			sda_oe_n_o <= 1'b1;
		end else begin
			sda_oe_n_o <= next_drive_rel; // R11
		end
	end

	// ==========================================================
	// User area memory
	optical_mgmt_mem #(
		.AW(MEM_AW),
		.DW(MEM_DW)
	) u_user_mem (
		.clk_i   (scl_i),
		.we_i    (mem_we),
		.waddr_i (ptr[MEM_AW-1:0]),
		.wdata_i (byte_in),
		.raddr_i (next_ptr[MEM_AW-1:0]),
		.rdata_o (mem_rdata)
	);

endmodule : optical_mgmt_port

// [pkg/optical_mgmt_pkg.sv]
// Constants and types shared by the transceiver management port.
// Assumes a 200 MHz core clock and a host-driven two-wire serial clock.
package optical_mgmt_pkg;

	// ==========================================================
	// Timing
	localparam int          CLK_MHZ      = 200;
	localparam int          INIT_TIME_US = 10;
	localparam int          INIT_CYC     = INIT_TIME_US * CLK_MHZ;
	localparam int          INIT_CW      = 12;
	localparam logic [1:0]  LINK_CLR_CYC = 2'h2;

	// ==========================================================
	// Serial slave addressing and memory map
	localparam logic [6:0]  DEV_ADDR     = 7'h50;
	localparam logic [7:0]  ADDR_FLAG0   = 8'h05;
	localparam logic [7:0]  ADDR_STATUS  = 8'h08;
	localparam logic [7:0]  USER_BASE    = 8'h80;
	localparam int          MEM_AW       = 7;
	localparam int          MEM_DW       = 8;
	localparam int          NUM_MON      = 5;
	localparam int          FLAG_W       = 4 * NUM_MON;
	localparam logic [7:0]  SNAP_RST     = 8'h00;

	// ==========================================================
	// Factory limits, index 0 temp, 1 bias, 2 tx power, 3 rx power, 4 supply
	localparam logic [NUM_MON-1:0][7:0] ALARM_HI = {8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'hf0};
	localparam logic [NUM_MON-1:0][7:0] WARN_HI  = {8'he0, 8'he0, 8'he0, 8'he0, 8'he0};
	localparam logic [NUM_MON-1:0][7:0] WARN_LO  = {8'h20, 8'h20, 8'h20, 8'h20, 8'h20};
	localparam logic [NUM_MON-1:0][7:0] ALARM_LO = {8'h10, 8'h10, 8'h10, 8'h10, 8'h10};

	// ==========================================================
	// Serial engine phases
	typedef enum logic [2:0] {
		PH_DEV,
		PH_WORD,
		PH_WRITE,
		PH_READ,
		PH_IGNORE
	} phase_t;

endpackage : optical_mgmt_pkg

// [rtl/optical_mgmt_mem.sv]
// Small byte memory for the host-writable user area.
// Assumes one clock for both ports; read data is registered.
`timescale 1ns/1ps
module optical_mgmt_mem #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input  wire logic          clk_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [DW-1:0] rdata_o
);

	logic [DW-1:0] store [0:(1<<AW)-1];

	// ==========================================================
	// Write port and registered read port
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			store[waddr_i] <= wdata_i;
		end
		rdata_o <= store[raddr_i];
	end

endmodule : optical_mgmt_mem

// [testbench/optical_mgmt_sva.sv]
// Concurrent checks on the pins of the optical management port.
// Assumes only the top-level ports are visible; bound in below.
`timescale 1ns/1ps
module optical_mgmt_sva
	import optical_mgmt_pkg::*;
(
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       scl_i,
	input wire logic       sda_oe_n_o,
	input wire logic       mod_desel_i,
	input wire logic       laser_off_request_i,
	input wire logic       power_down_i,
	input wire logic       rx_signal_detect_i,
	input wire logic [7:0] mon_temp_i,
	input wire logic [7:0] mon_bias_i,
	input wire logic [7:0] mon_txpwr_i,
	input wire logic [7:0] mon_rxpwr_i,
	input wire logic [7:0] mon_vcc_i,
	input wire logic       interrupt_n_o,
	input wire logic       mod_absent_o,
	input wire logic       not_ready_flag_o,
	input wire logic       receive_signal_lost_o,
	input wire logic       laser_enable_o,
	input wire logic       standby_o
);
	// ==========================================================
	// Helper: every monitor strictly inside its warning band
	logic [NUM_MON-1:0][7:0] mon;
	logic                    calm;
	assign mon = {mon_vcc_i, mon_rxpwr_i, mon_txpwr_i, mon_bias_i, mon_temp_i};
	always_comb begin
		calm = 1'b1;
		for (int i = 0; i < NUM_MON; i++) begin
			calm = calm && (mon[i] > WARN_LO[i]) && (mon[i] < WARN_HI[i]);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// ==========================================================
	// Pins; windows of three or four cycles cover the two-flop synchronisers
	absent_low_a: assert property (mod_absent_o == 1'b0)
		else $error("absent output high");
	laser_dark_a: assert property (laser_off_request_i [*4] |-> !laser_enable_o)
		else $error("laser on while disable requested");
	standby_hold_a: assert property (power_down_i [*4] |-> standby_o && !laser_enable_o)
		else $error("standby not entered");
	loss_level_a: assert property (
		$stable(rx_signal_detect_i) [*4] |-> receive_signal_lost_o == !rx_signal_detect_i)
		else $error("loss output wrong");
	irq_quiet_a: assert property (calm [*3] |-> interrupt_n_o)
		else $error("interrupt without condition");
	irq_alarm_a: assert property ((!not_ready_flag_o && mon_temp_i > ALARM_HI[0]) [*4] |-> !interrupt_n_o)
		else $error("interrupt missing on alarm");
	// ==========================================================
	// Serial side: the module only moves its data driver while the clock is low
	oe_edge_a: assert property (sda_oe_n_o != $past(sda_oe_n_o) |-> !scl_i)
		else $error("data driver moved with clock high");
	desel_quiet_a: assert property (mod_desel_i [*4] |-> sda_oe_n_o)
		else $error("deselected module drove data");
	pd_reset_a: assert property ($fell(power_down_i) |-> ##[1:8] not_ready_flag_o)
		else $error("no reset after power-down fall");
endmodule : optical_mgmt_sva

bind optical_mgmt_port optical_mgmt_sva i_sva (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o), .mod_desel_i(mod_desel_i),
	.laser_off_request_i(laser_off_request_i), .power_down_i(power_down_i),
	.rx_signal_detect_i(rx_signal_detect_i), .mon_temp_i(mon_temp_i), .mon_bias_i(mon_bias_i),
	.mon_txpwr_i(mon_txpwr_i), .mon_rxpwr_i(mon_rxpwr_i), .mon_vcc_i(mon_vcc_i),
	.interrupt_n_o(interrupt_n_o), .mod_absent_o(mod_absent_o), .not_ready_flag_o(not_ready_flag_o),
	.receive_signal_lost_o(receive_signal_lost_o), .laser_enable_o(laser_enable_o), .standby_o(standby_o)
);

// [testbench/host_serial_model.sv]
// Host model of the two-wire bus: clock master, open-drain data, pull-up.
// Assumes the module pulls low only when its enable is low.
`timescale 1ns/1ps
module host_serial_model (
	output logic      scl_o,
	output logic      sda_o,
	input  wire logic dev_sda_i,
	input  wire logic dev_oe_n_i
);
	// ==========================================================
	// Bit timer: 15 ns tick, 12 ticks (180 ns) per serial clock period, phase unrelated to the core
	logic tick = 1'b0;
	logic pull = 1'b0;
	initial begin
		#3.3;
		forever #7.5 tick = ~tick;
	end
	initial scl_o = 1'b1;
	// Pull-up wins unless either side pulls low
	assign sda_o = ~pull & (dev_oe_n_i | dev_sda_i);

	task automatic hw(input int n);
		repeat (n) @(posedge tick);
	endtask : hw
	// Start or repeated start; clock stands high between frames
	task automatic start;
		pull = 1'b0;
		hw(1);
		scl_o = 1'b1;
		hw(5);
		pull = 1'b1;
		hw(5);
		scl_o = 1'b0;
		hw(2);
	endtask : start
	task automatic stop;
		pull = 1'b1;
		hw(2);
		scl_o = 1'b1;
		hw(5);
		pull = 1'b0;
		hw(5);
	endtask : stop
	// Data moves two ticks after the falling clock so it never mimics a start
	task automatic bitx(input logic b, output logic r);
		pull = ~b;
		hw(5);
		scl_o = 1'b1;
		hw(3);
		r = sda_o;
		hw(2);
		scl_o = 1'b0;
		hw(2);
	endtask : bitx
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, r);
		ack = ~r;
	endtask : wbyte
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(last, r);
	endtask : rbyte
endmodule : host_serial_model

// [testbench/tb_top.sv]
// Self-checking bench for the optical management port.
// Assumes the host model above and a shortened init count.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
	$display("mismatch at %0t got %h expected %h", $time, (a), (e)); end end
module tb_top;
	import optical_mgmt_pkg::*;
	logic            clk_i = 1'b0;
	logic            rst_n_i = 1'b0;
	logic            scl, sda, dev_sda, dev_oe_n, ack;
	logic            mod_desel = 1'b0;
	logic            laser_off = 1'b0;
	logic            pdown = 1'b0;
	logic            rx_det = 1'b1;
	logic [4:0][7:0] mon = {5{8'h80}};
	logic            irq_n, absent, not_ready, los, laser_en, standby;
	logic [7:0]      rb [8];
	int              failures = 0;
	int              n_checks = 0;

	always #2.5 clk_i = ~clk_i;

	optical_mgmt_port #(.INIT_CYCLES(8)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
		.sda_o(dev_sda), .sda_oe_n_o(dev_oe_n), .mod_desel_i(mod_desel), .laser_off_request_i(laser_off),
		.power_down_i(pdown), .rx_signal_detect_i(rx_det), .mon_temp_i(mon[0]), .mon_bias_i(mon[1]),
		.mon_txpwr_i(mon[2]), .mon_rxpwr_i(mon[3]), .mon_vcc_i(mon[4]), .interrupt_n_o(irq_n),
		.mod_absent_o(absent), .not_ready_flag_o(not_ready), .receive_signal_lost_o(los),
		.laser_enable_o(laser_en), .standby_o(standby));
	host_serial_model i_host (.scl_o(scl), .sda_o(sda), .dev_sda_i(dev_sda), .dev_oe_n_i(dev_oe_n));

	// ==========================================================
	// Shared helpers; core-side inputs always change 1 ns after a clock edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic wait_flag(input logic v);
		int k = 0;
		while (not_ready !== v && k < 100) begin
			cyc(1);
			k++;
		end
		`CHK(not_ready, v);
	endtask : wait_flag
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
		i_host.start();
		i_host.wbyte({DEV_ADDR, 1'b0}, ack);
		`CHK(ack, 1'b1);
		i_host.wbyte(a, ack);
		for (int i = 0; i < n; i++) begin
			i_host.wbyte(d + 8'(i), ack);
			`CHK(ack, 1'b1);
		end
		i_host.stop();
	endtask : wr
	task automatic rd(input logic [7:0] a, input int n);
		i_host.start();
		i_host.wbyte({DEV_ADDR, 1'b0}, ack);
		i_host.wbyte(a, ack);
		i_host.start();
		i_host.wbyte({DEV_ADDR, 1'b1}, ack);
		`CHK(ack, 1'b1);
		for (int i = 0; i < n; i++) begin
			i_host.rbyte(i == n - 1, rb[i]);
		end
		i_host.stop();
	endtask : rd

	// ==========================================================
	// Scenarios
	task automatic t_pins;
		laser_off = 1'b1;
		cyc(4);
		`CHK(laser_en, 1'b0);
		laser_off = 1'b0;
		rx_det = 1'b0;
		cyc(4);
		`CHK(laser_en, 1'b1);
		`CHK(los, 1'b1);
		rx_det = 1'b1;
		cyc(4);
		`CHK(los, 1'b0);
		`CHK(absent, 1'b0);
		`CHK(standby, 1'b0);
		`CHK(dev_sda, 1'b0);
	endtask : t_pins
	// User area keeps data; the protected byte at zero keeps its live value
	task automatic t_mem;
		for (int i = 0; i < 5; i++) begin
			mon[i] = 8'h81 + 8'(i);
		end
		wr(8'h80, 8'ha5, 2);
		wr(8'h00, 8'h77, 1);
		rd(8'h80, 2);
		`CHK(rb[0], 8'ha5);
		`CHK(rb[1], 8'ha6);
		rd(8'h00, 5);
		for (int i = 0; i < 5; i++) begin
			`CHK(rb[i], mon[i]);
		end
	endtask : t_mem
	task automatic t_irq;
		cyc(1);
		mon[0] = 8'hf5;
		mon[4] = 8'h05;
		cyc(4);
		`CHK(irq_n, 1'b0);
		rd(8'h05, 3);
		`CHK(rb[0], 8'h0a);
		`CHK(rb[1], 8'h00);
		`CHK(rb[2], 8'h05);
		cyc(1);
		mon[0] = 8'h81;
		mon[4] = 8'h85;
		cyc(4);
		`CHK(irq_n, 1'b1);
	endtask : t_irq
	task automatic t_desel;
		mod_desel = 1'b1;
		cyc(4);
		i_host.start();
		i_host.wbyte({DEV_ADDR, 1'b0}, ack);
		`CHK(ack, 1'b0);
		i_host.stop();
		cyc(1);
		mod_desel = 1'b0;
		cyc(12);
	endtask : t_desel
	// After a power-down fall the pointer is back at zero
	task automatic t_pdown;
		pdown = 1'b1;
		cyc(5);
		`CHK(standby, 1'b1);
		`CHK(laser_en, 1'b0);
		pdown = 1'b0;
		wait_flag(1'b1);
		`CHK(not_ready, 1'b1);
		wait_flag(1'b0);
		cyc(12);
		i_host.start();
		i_host.wbyte({DEV_ADDR, 1'b1}, ack);
		i_host.rbyte(1'b1, rb[0]);
		i_host.stop();
		`CHK(rb[0], mon[0]);
	endtask : t_pdown

	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	initial begin
		cyc(20);
		`CHK(not_ready, 1'b1);
		`CHK(irq_n, 1'b1);
		rst_n_i = 1'b1;
		wait_flag(1'b0);
		`CHK(not_ready, 1'b0);
		cyc(12);
		t_pins();
		t_mem();
		t_irq();
		t_desel();
		t_pdown();
		give_verdict();
	end
	// Watchdog well beyond the longest expected run
	initial begin
		#150us;
		failures++;
		give_verdict();
	end
endmodule : tb_top
